// >>> src/weekly_switch.sv
`timescale 1ns/1ps
module weekly_switch #(
    parameter int N_INST     = wsw_pkg::NUM_INST,
    parameter int SEC_CYCLES = wsw_pkg::SEC_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [11:0]       s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [11:0]       s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              main_power_ok,
    output logic [N_INST-1:0]      weekly_switch_contact
);
    localparam logic [6:0] LAST_IDX = 7'(N_INST * wsw_pkg::NUM_CHAN - 1);

    if (N_INST < 1 || N_INST > wsw_pkg::NUM_INST) begin : g_bad_inst
        $error("N_INST out of range");
    end
    if (SEC_CYCLES < 2) begin : g_bad_sec
        $error("SEC_CYCLES too small");
    end

    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    arready;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [31:0]             presc;
        logic [5:0]              sec;
        logic [10:0]             mod;
        logic [2:0]              wday;
        logic [4:0]              day;
        logic [3:0]              mon;
        logic [6:0]              yr;
        logic                    pwr_q1;
        logic                    pwr_q2;
        logic                    pwr_prev;
        logic                    tick_pend;
        logic                    replay;
        logic [13:0]             rp_cnt;
        logic [2:0]              rp_wday;
        logic [10:0]             rp_mod;
        wsw_pkg::scan_state_type st;
        logic [6:0]              idx;
        logic [2:0]              ev_wday;
        logic [10:0]             ev_mod;
        logic                    on_acc;
        logic                    off_acc;
        logic [31:0]             contact_int;
        logic [31:0]             contact_out;
    } state_type;

    state_type             s_r;
    state_type             s_nxt;
    logic [31:0]           cfg_mem [0:127];
    wsw_pkg::chan_cfg_type cfg;
    wsw_pkg::time_reg_type time_now;
    wsw_pkg::date_reg_type date_now;
    logic [11:0]           wcfg_off;
    logic [11:0]           rcfg_off;
    logic                  wr_cfg;
    logic                  rd_cfg;
    logic                  on_hit;
    logic                  off_hit;
    logic                  off_now;
    logic                  on_now;
    logic [2:0]            prev_wday;
    logic                  minute_tick;
    wsw_pkg::time_reg_type time_wr;
    wsw_pkg::date_reg_type date_wr;

    assign cfg       = wsw_pkg::chan_cfg_type'(cfg_mem[s_r.idx]);
    assign time_now  = '{rsvd: 12'h000, wday: s_r.wday, mod: s_r.mod, sec: s_r.sec};
    assign date_now  = '{rsvd: 16'h0000, yr: s_r.yr, mon: s_r.mon, day: s_r.day};
    assign wcfg_off  = s_axi_awaddr - wsw_pkg::ADDR_CFG;
    assign rcfg_off  = s_axi_araddr - wsw_pkg::ADDR_CFG;
    assign wr_cfg    = (s_axi_awaddr >= wsw_pkg::ADDR_CFG) && (wcfg_off[11:2] <= 10'(LAST_IDX));
    assign rd_cfg    = (s_axi_araddr >= wsw_pkg::ADDR_CFG) && (rcfg_off[11:2] <= 10'(LAST_IDX));
    assign prev_wday = (s_r.ev_wday == 3'h0) ? wsw_pkg::LAST_WDAY : s_r.ev_wday - 3'h1;
    assign minute_tick = (s_r.presc == 32'(SEC_CYCLES - 1)) && (s_r.sec == wsw_pkg::LAST_SEC);
    assign time_wr   = wsw_pkg::time_reg_type'(
                           wsw_pkg::merge(time_now, s_axi_wdata, s_axi_wstrb));
    assign date_wr   = wsw_pkg::date_reg_type'(
                           wsw_pkg::merge(date_now, s_axi_wdata, s_axi_wstrb));

    // channel edge detection for the minute under evaluation
    always_comb begin
        on_hit = (cfg.on_t != wsw_pkg::TIME_NONE) && (cfg.on_t == s_r.ev_mod)      // [RL7] [RL9]
                 && wsw_pkg::in_span(cfg.first_day_setting, cfg.last_day_setting,
                                     s_r.ev_wday);                                 // [RL5] [RL6]
        off_hit = 1'b0;
        if (cfg.off_t != wsw_pkg::TIME_NONE && cfg.off_t == s_r.ev_mod) begin      // [RL7] [RL9]
            if (cfg.on_t != wsw_pkg::TIME_NONE && cfg.off_t < cfg.on_t) begin
                // off lands on the day after the on edge
                off_hit = wsw_pkg::in_span(cfg.first_day_setting, cfg.last_day_setting,
                                           prev_wday);                             // [RL10]
            end else begin
                off_hit = wsw_pkg::in_span(cfg.first_day_setting, cfg.last_day_setting,
                                           s_r.ev_wday);                           // [RL8]
            end
        end
        off_now = s_r.off_acc || off_hit;
        on_now  = s_r.on_acc || on_hit;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.awready = 1'b0;
        s_nxt.wready  = 1'b0;
        s_nxt.arready = 1'b0;
        if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
        if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;

        // power pin synchroniser
        s_nxt.pwr_q1   = main_power_ok;
        s_nxt.pwr_q2   = s_r.pwr_q1;
        s_nxt.pwr_prev = s_r.pwr_q2;

        // calendar keeps running whatever the power state
        if (s_r.presc == 32'(SEC_CYCLES - 1)) begin
            s_nxt.presc = 32'h0;
            if (s_r.sec == wsw_pkg::LAST_SEC) begin
                s_nxt.sec       = 6'h00;
                s_nxt.tick_pend = 1'b1;                                            // [RL16]
                if (s_r.mod == wsw_pkg::LAST_MOD) begin
                    s_nxt.mod  = 11'h000;
                    s_nxt.wday = (s_r.wday == wsw_pkg::LAST_WDAY) ? 3'h0 : s_r.wday + 3'h1;
                    if (s_r.day == wsw_pkg::days_in_month(s_r.mon, s_r.yr)) begin
                        s_nxt.day = wsw_pkg::RST_DAY;
                        if (s_r.mon == wsw_pkg::LAST_MON) begin
                            s_nxt.mon = wsw_pkg::RST_MON;
                            s_nxt.yr  = (s_r.yr == wsw_pkg::YEAR_LAST) ?
                                        wsw_pkg::YEAR_FIRST : s_r.yr + 7'h01;      // [RL4]
                        end else begin
                            s_nxt.mon = s_r.mon + 4'h1;
                        end
                    end else begin
                        s_nxt.day = s_r.day + 5'h01;
                    end
                end else begin
                    s_nxt.mod = s_r.mod + 11'h001;
                end
            end else begin
                s_nxt.sec = s_r.sec + 6'h01;
            end
        end else begin
            s_nxt.presc = s_r.presc + 32'h1;
        end

        // register writes: address and data taken together
        if (s_axi_awvalid && s_axi_wvalid && !s_r.bvalid && !s_r.awready) begin
            s_nxt.awready = 1'b1;
            s_nxt.wready  = 1'b1;
        end
        if (s_r.awready) begin
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = wsw_pkg::RESP_OKAY;
            if (s_axi_awaddr[11:2] == wsw_pkg::ADDR_TIME[11:2]) begin
                // out-of-range fields would run the counters past their wrap points
                s_nxt.sec   = (time_wr.sec > wsw_pkg::LAST_SEC) ? 6'h00 : time_wr.sec;
                s_nxt.mod   = (time_wr.mod > wsw_pkg::LAST_MOD) ? 11'h000 : time_wr.mod; // [RL7]
                s_nxt.wday  = (time_wr.wday > wsw_pkg::LAST_WDAY) ? wsw_pkg::RST_WDAY :
                              time_wr.wday;
                s_nxt.presc = 32'h0;
            end else if (s_axi_awaddr[11:2] == wsw_pkg::ADDR_DATE[11:2]) begin
                s_nxt.day = date_wr.day;
                s_nxt.mon = date_wr.mon;
                s_nxt.yr  = (date_wr.yr < wsw_pkg::YEAR_FIRST ||
                             date_wr.yr > wsw_pkg::YEAR_LAST) ?
                            wsw_pkg::YEAR_FIRST : date_wr.yr; // [RL4]
            end else if (!wr_cfg && s_axi_awaddr[11:2] != wsw_pkg::ADDR_STAT[11:2]
                         && s_axi_awaddr[11:2] != wsw_pkg::ADDR_CONT[11:2]) begin
                s_nxt.bresp = wsw_pkg::RESP_SLVERR;
            end
        end

        // register reads
        if (s_axi_arvalid && !s_r.arready && !s_r.rvalid) s_nxt.arready = 1'b1;
        if (s_r.arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = wsw_pkg::RESP_OKAY;
            s_nxt.rdata  = 32'h0;
            if (s_axi_araddr[11:2] == wsw_pkg::ADDR_TIME[11:2]) begin
                s_nxt.rdata = time_now;
            end else if (s_axi_araddr[11:2] == wsw_pkg::ADDR_DATE[11:2]) begin
                s_nxt.rdata = date_now;
            end else if (s_axi_araddr[11:2] == wsw_pkg::ADDR_STAT[11:2]) begin
                s_nxt.rdata = {30'h0, s_r.replay, s_r.pwr_q2};
            end else if (s_axi_araddr[11:2] == wsw_pkg::ADDR_CONT[11:2]) begin
                s_nxt.rdata = s_r.contact_out;
            end else if (rd_cfg) begin
                s_nxt.rdata = cfg_mem[rcfg_off[8:2]];
            end else begin
                s_nxt.rresp = wsw_pkg::RESP_SLVERR;
            end
        end

        // power return: rebuild every contact by replaying the past week
        if (s_r.pwr_q2 && !s_r.pwr_prev) begin
            s_nxt.replay      = 1'b1;                                              // [RL14]
            s_nxt.rp_cnt      = wsw_pkg::WEEK_MIN;
            s_nxt.rp_wday     = s_r.wday;
            s_nxt.rp_mod      = s_r.mod;
            s_nxt.contact_int = 32'h0;
            s_nxt.tick_pend   = minute_tick;
            s_nxt.st          = wsw_pkg::ST_IDLE;
        end else if (!s_r.pwr_q2) begin
            // no switching while unpowered
            s_nxt.replay = 1'b0;                                                   // [RL3]
            s_nxt.st     = wsw_pkg::ST_IDLE;
        end else begin
            case (s_r.st)
                wsw_pkg::ST_IDLE: begin
                    s_nxt.idx     = 7'h00;
                    s_nxt.on_acc  = 1'b0;
                    s_nxt.off_acc = 1'b0;
                    if (s_r.replay && s_r.rp_cnt != 14'h0000) begin
                        // step first, so the last replayed minute is the present one
                        s_nxt.rp_mod  = (s_r.rp_mod == wsw_pkg::LAST_MOD) ? 11'h000 :
                                        s_r.rp_mod + 11'h001;
                        s_nxt.rp_wday = (s_r.rp_mod != wsw_pkg::LAST_MOD) ? s_r.rp_wday :
                                        (s_r.rp_wday == wsw_pkg::LAST_WDAY) ? 3'h0 :
                                        s_r.rp_wday + 3'h1;
                        s_nxt.ev_mod  = s_nxt.rp_mod;
                        s_nxt.ev_wday = s_nxt.rp_wday;
                        s_nxt.rp_cnt  = s_r.rp_cnt - 14'h0001;
                        s_nxt.st      = wsw_pkg::ST_SCAN;                          // [RL14]
                    end else if (s_r.replay) begin
                        s_nxt.replay = 1'b0;
                    end else if (s_r.tick_pend) begin
                        // a tick landing in this very cycle stays pending: set wins
                        s_nxt.tick_pend = minute_tick;
                        s_nxt.ev_mod    = s_r.mod;
                        s_nxt.ev_wday   = s_r.wday;
                        s_nxt.st        = wsw_pkg::ST_SCAN;                        // [RL16]
                    end
                end
                wsw_pkg::ST_SCAN: begin
                    s_nxt.on_acc  = on_now;
                    s_nxt.off_acc = off_now;
                    if (s_r.idx[1:0] == 2'h3) begin
                        // all four channels seen: off beats on within the minute
                        if (off_now) begin
                            s_nxt.contact_int[s_r.idx[6:2]] = 1'b0;                // [RL12] [RL13]
                        end else if (on_now) begin
                            s_nxt.contact_int[s_r.idx[6:2]] = 1'b1;                // [RL11] [RL2]
                        end
                        s_nxt.on_acc  = 1'b0;
                        s_nxt.off_acc = 1'b0;
                    end
                    if (s_r.idx == LAST_IDX) begin
                        s_nxt.st = wsw_pkg::ST_IDLE;
                    end else begin
                        s_nxt.idx = s_r.idx + 7'h01;                               // [RL1]
                    end
                end
                default: s_nxt.st = wsw_pkg::ST_IDLE;
            endcase
        end

        // contacts open while unpowered, on the first powered cycle and while rebuilding,
        // so the state from before the outage never reaches the pins
        s_nxt.contact_out = (s_r.pwr_q2 && s_r.pwr_prev && !s_r.replay) ?
                            s_r.contact_int : 32'h0; // [RL3] [RL15]
    end

    always_ff @(posedge clk) begin
        if (s_r.awready && wr_cfg) begin
            cfg_mem[wcfg_off[8:2]] <= wsw_pkg::merge(cfg_mem[wcfg_off[8:2]], s_axi_wdata,
                                                     s_axi_wstrb);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r      <= '0;
            s_r.day  <= wsw_pkg::RST_DAY;
            s_r.mon  <= wsw_pkg::RST_MON;
            s_r.yr   <= wsw_pkg::YEAR_FIRST;
            s_r.wday <= wsw_pkg::RST_WDAY;
            s_r.st   <= wsw_pkg::ST_IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign s_axi_awready         = s_r.awready;
    assign s_axi_wready          = s_r.wready;
    assign s_axi_bvalid          = s_r.bvalid;
    assign s_axi_bresp           = s_r.bresp;
    assign s_axi_arready         = s_r.arready;
    assign s_axi_rvalid          = s_r.rvalid;
    assign s_axi_rresp           = s_r.rresp;
    assign s_axi_rdata           = s_r.rdata;
    assign weekly_switch_contact = s_r.contact_out[N_INST-1:0];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    logic scan_end;
    assign scan_end = (s_r.st == wsw_pkg::ST_SCAN) && (s_r.idx[1:0] == 2'h3) && s_r.pwr_q2
                      && !(s_r.pwr_q2 && !s_r.pwr_prev);

    property p_open_unpowered;
        !s_r.pwr_q2 |=> s_r.contact_out == 32'h0 ##1 s_r.contact_out == 32'h0;
    endproperty
    a_open_unpowered: assert property (p_open_unpowered) else $error("closed unpowered"); // [RL3]
    property p_off_wins;
        scan_end && off_now |=> !s_r.contact_int[$past(s_r.idx[6:2])];
    endproperty
    a_off_wins: assert property (p_off_wins) else $error("off edge did not open"); // [RL12]
    property p_on_sets;
        scan_end && !off_now && on_now |=> s_r.contact_int[$past(s_r.idx[6:2])];
    endproperty
    a_on_sets: assert property (p_on_sets) else $error("on edge did not close"); // [RL11]
    property p_equal_off;
        s_r.st == wsw_pkg::ST_SCAN && cfg.on_t == cfg.off_t && on_hit |-> off_hit;
    endproperty
    a_equal_off: assert property (p_equal_off) else $error("equal times not off"); // [RL13]
    property p_chan_group;
        s_r.st == wsw_pkg::ST_SCAN && s_r.idx[1:0] != 2'h3 && s_r.pwr_q2 && s_r.pwr_prev
            |=> $stable(s_r.contact_int);
    endproperty
    a_chan_group: assert property (p_chan_group) else $error("contact moved mid group"); // [RL2]
    property p_replay_hold;
        s_r.replay |=> s_r.contact_out == 32'h0;
    endproperty
    a_replay_hold: assert property (p_replay_hold) else $error("shown while rebuilding"); // [RL14]
    property p_publish;
        s_r.pwr_q2 && s_r.pwr_prev && !s_r.replay |=> s_r.contact_out == $past(s_r.contact_int);
    endproperty
    a_publish: assert property (p_publish) else $error("contact not published"); // [RL15]
    property p_year_range;
        s_r.yr >= wsw_pkg::YEAR_FIRST && s_r.yr <= wsw_pkg::YEAR_LAST;
    endproperty
    a_year_range: assert property (p_year_range) else $error("year out of range"); // [RL4]
    property p_scan_step;
        s_r.st == wsw_pkg::ST_SCAN && s_r.idx != LAST_IDX && s_r.pwr_q2 && s_r.pwr_prev
            |=> s_r.idx == $past(s_r.idx) + 7'h01;
    endproperty
    a_scan_step: assert property (p_scan_step) else $error("scan skipped a channel"); // [RL16]
    property p_time_range;
        s_r.mod <= wsw_pkg::LAST_MOD && s_r.ev_mod <= wsw_pkg::LAST_MOD;
    endproperty
    a_time_range: assert property (p_time_range) else $error("minute out of range"); // [RL7]

    c_replay_done: cover property ($fell(s_r.replay) && s_r.pwr_q2);
    c_off_wins:    cover property (scan_end && off_hit && on_now);
    c_overnight:   cover property (off_hit && cfg.off_t < cfg.on_t);
    c_live_scan:   cover property (!s_r.replay && $rose(s_r.st == wsw_pkg::ST_SCAN));
endmodule : weekly_switch

// >>> src/wsw_pkg.sv
// Summary of operation
// RL1: up to 32 independent weekly switch instances
// RL2: four channels per instance share one contact
// RL3: unpowered: clock runs, contacts held open
// RL4: calendar runs 2001-01-01 through 2099-12-31
// RL5: first day starts span, last day ends
// RL6: day codes Monday to Sunday or none
// RL7: times 00:00 to 23:59 or none
// RL8: span with both times switches daily
// RL9: single time gives only that edge
// RL10: off before on switches off next day
// RL11: earliest on edge closes the contact
// RL12: earliest off edge opens the contact
// RL13: equal on and off times give off
// RL14: power-up recomputes every contact from settings
// RL15: contact closed in on period, else open
// RL16: compare once per minute, one edge each
package wsw_pkg;
    localparam int NUM_INST      = 32;
    localparam int NUM_CHAN      = 4;
    localparam int SECOND_NS     = 1_000_000_000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SEC_CYCLES    = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [13:0] WEEK_MIN   = 14'h2760;
    localparam logic [2:0]  DAY_NONE   = 3'h7;
    localparam logic [2:0]  LAST_WDAY  = 3'h6;
    localparam logic [10:0] TIME_NONE  = 11'h7FF;
    localparam logic [10:0] LAST_MOD   = 11'h59F;
    localparam logic [5:0]  LAST_SEC   = 6'h3B;
    localparam logic [3:0]  LAST_MON   = 4'hC;
    localparam logic [6:0]  YEAR_FIRST = 7'h01;
    localparam logic [6:0]  YEAR_LAST  = 7'h63;
    localparam logic [4:0]  RST_DAY    = 5'h01;
    localparam logic [3:0]  RST_MON    = 4'h1;
    localparam logic [2:0]  RST_WDAY   = 3'h0;
    localparam logic [11:0] ADDR_TIME  = 12'h000;
    localparam logic [11:0] ADDR_DATE  = 12'h004;
    localparam logic [11:0] ADDR_STAT  = 12'h008;
    localparam logic [11:0] ADDR_CONT  = 12'h00C;
    localparam logic [11:0] ADDR_CFG   = 12'h100;
    localparam logic [1:0]  RESP_OKAY  = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

    typedef enum logic [0:0] {ST_IDLE, ST_SCAN} scan_state_type;

    typedef struct packed {
        logic [11:0] rsvd;
        logic [2:0]  wday;
        logic [10:0] mod;
        logic [5:0]  sec;
    } time_reg_type;

    typedef struct packed {
        logic [15:0] rsvd;
        logic [6:0]  yr;
        logic [3:0]  mon;
        logic [4:0]  day;
    } date_reg_type;

    typedef struct packed {
        logic        rsvd1;
        logic [10:0] off_t;
        logic        rsvd0;
        logic [10:0] on_t;
        logic [1:0]  rsvd;
        logic [2:0]  last_day_setting;
        logic [2:0]  first_day_setting;
    } chan_cfg_type;

    function automatic logic [4:0] days_in_month(input logic [3:0] mon, input logic [6:0] yr);
        case (mon)
            4'h4, 4'h6, 4'h9, 4'hB: days_in_month = 5'h1E;
            4'h2: days_in_month = (yr[1:0] == 2'h0) ? 5'h1D : 5'h1C;
            default: days_in_month = 5'h1F;
        endcase
    endfunction : days_in_month

    function automatic logic in_span(input logic [2:0] f, input logic [2:0] l,
                                     input logic [2:0] d);
        logic [2:0] a;
        logic [2:0] b;
        a = (f == DAY_NONE) ? l : f;
        b = (l == DAY_NONE) ? a : l;
        if (a == DAY_NONE) begin
            in_span = 1'b0;
        end else if (a <= b) begin
            in_span = (d >= a) && (d <= b);
        end else begin
            in_span = (d >= a) || (d <= b);
        end
    endfunction : in_span

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        merge = (old & ~m) | (wd & m);
    endfunction : merge
endpackage : wsw_pkg

// >>> tb/tb_weekly_switch.sv
`timescale 1ns/1ps
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_weekly_switch;
    localparam logic [11:0] CFG = wsw_pkg::ADDR_CFG;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        pwr = 1'b1;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [0:0]  contact;
    logic [31:0] seed = 32'h3CCF5A4C;
    int          num_errors = 0;
    int          n_compared = 0;

    always #5 clk = ~clk;

    weekly_switch #(.N_INST(1), .SEC_CYCLES(4)) u_dut (
        .clk(clk), .rst_n(rst_n), .main_power_ok(pwr), .weekly_switch_contact(contact),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [31:0] cw(input logic [2:0] f, input logic [2:0] l,
                                       input logic [10:0] on_m, input logic [10:0] off_m);
        return {1'b0, off_m, 1'b0, on_m, 2'h0, l, f};
    endfunction : cw

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk);
            if (awready === 1'b1) ad = 1'b1;
            if (wready === 1'b1) wd = 1'b1;
            awvalid <= !ad;
            wvalid <= !wd;
        end
        while (bvalid !== 1'b1) @(posedge clk);
        r = bresp;
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (arready !== 1'b1) @(posedge clk);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : rd

    // second 59 is written so the minute edge lands a few cycles later
    task automatic step(input logic [2:0] wd, input logic [10:0] m, input logic c);
        logic [1:0] r;
        wr(wsw_pkg::ADDR_TIME, {12'h000, wd, m, 6'h3B}, 4'hF, r);
        repeat (20) @(posedge clk);
        `CHK(contact, c);
    endtask : step

    // the week replay dominates run time, so only one instance is built
    task automatic wait_idle();
        logic [31:0] d;
        logic [1:0]  r;
        repeat (10) @(posedge clk);
        d = 32'h2;
        while (d[1] !== 1'b0) rd(wsw_pkg::ADDR_STAT, d, r);
    endtask : wait_idle

    task automatic results();
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : results

    initial begin
        repeat (110000) @(posedge clk);
        num_errors++;
        results();
    end

    initial begin
        logic [31:0] d, x, y;
        logic [1:0]  r;
        logic [3:0]  s;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        x = rnd();
        y = rnd();
        s = 4'(rnd());
        wr(CFG + 12'h00C, x, 4'hF, r);
        wr(CFG + 12'h00C, y, s, r);
        rd(CFG + 12'h00C, d, r);
        for (int i = 0; i < 4; i++) begin
            if (s[i] == 1'b1) x[8*i +: 8] = y[8*i +: 8];
        end
        `CHK(d, x);
        wr(CFG + 12'h010, y, 4'hF, r);
        `CHK(r, wsw_pkg::RESP_SLVERR);
        rd(CFG + 12'h010, d, r);
        `CHK(r, wsw_pkg::RESP_SLVERR);
        `CHK(d, 32'h0);
        wr(wsw_pkg::ADDR_DATE, {16'h0000, 7'h64, 4'hC, 5'h1F}, 4'hF, r);
        rd(wsw_pkg::ADDR_DATE, d, r);
        `CHK(d, {16'h0000, wsw_pkg::YEAR_FIRST, 4'hC, 5'h1F});
        wr(CFG, cw(3'h0, 3'h4, 11'h258, 11'h438), 4'hF, r);
        wr(CFG + 12'h004, cw(3'h0, 3'h7, 11'h528, 11'h168), 4'hF, r);
        wr(CFG + 12'h008, cw(3'h6, 3'h6, 11'h2D0, 11'h2D0), 4'hF, r);
        wr(CFG + 12'h00C, cw(3'h6, 3'h7, 11'h294, 11'h7FF), 4'hF, r);
        wait_idle();
        `CHK(contact, 1'b0);
        step(3'h0, 11'h257, 1'b1);
        step(3'h0, 11'h167, 1'b1);
        step(3'h1, 11'h437, 1'b0);
        step(3'h5, 11'h257, 1'b0);
        step(3'h0, 11'h527, 1'b1);
        step(3'h1, 11'h167, 1'b0);
        step(3'h6, 11'h293, 1'b1);
        step(3'h6, 11'h2CF, 1'b0);
        step(3'h0, 11'h257, 1'b1);
        pwr <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(contact, 1'b0);
        step(3'h0, 11'h257, 1'b0);
        pwr <= 1'b1;
        wait_idle();
        `CHK(contact, 1'b1);
        rd(wsw_pkg::ADDR_CONT, d, r);
        `CHK(d, 32'h1);
        results();
    end
endmodule : tb_weekly_switch
